/* src/fds_supervisor.sv */
`include "fds_regs.svh"

module fds_supervisor #(
    parameter logic [7:0] ID_CODE = 8'hA5 // arbitrary value
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic uvlo,
    input wire logic vout_at_max,
    input wire logic src_drop_low,
    input wire logic led_out_low,
    input wire logic led_cur_above_min,
    input wire logic die_hot,
    input wire logic die_cool,
    input wire logic cap_above_2v4,
    input wire logic cell_short,
    input wire logic ntc_low,
    input wire logic cur_reduced,
    input wire logic [7:0] reduced_value,
    input wire logic charge_done,
    input wire logic strobe_pin,
    input wire logic adc_done,
    input wire logic [9:0] adc_data,
    output logic [2:0] mode,
    output logic dcdc_en,
    output logic sink_en,
    output logic ramp_down,
    output logic charge_pause,
    output logic [1:0] txm_mode,
    output logic [5:0] adc_channel,
    output logic adc_start,
    output logic int_o,
    output logic int_oe_n
);
    import fds_pkg::*;

    // ======================================================
    // helpers
    function automatic logic is_off(input logic [2:0] m);
        is_off = (m == `FDS_M_OFF) || (m == `FDS_M_DISCH);
    endfunction : is_off

    function automatic logic is_chg(input logic [2:0] m);
        is_chg = (m == `FDS_M_PRECHG) || (m == `FDS_M_CHG) ||
                 (m == `FDS_M_TRANS);
    endfunction : is_chg

    // ======================================================
    // pin synchronisers, first stage read only by second
    logic [`FDS_NSYNC-1:0] sy_in;
    logic [`FDS_NSYNC-1:0] sy1_reg;
    logic [`FDS_NSYNC-1:0] sy2_reg;
    logic [7:0] rv1_reg;
    logic [7:0] rv2_reg;
    logic [9:0] ad1_reg;
    logic [9:0] ad2_reg;
    assign sy_in = {cur_reduced, 1'b0, adc_done, strobe_pin,
                    charge_done, ntc_low, cell_short, cap_above_2v4,
                    die_cool, die_hot, led_cur_above_min, led_out_low,
                    src_drop_low, vout_at_max, uvlo, 1'b0};
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sy1_reg <= '0;
            sy2_reg <= '0;
            rv1_reg <= `FDS_R8_RST;
            rv2_reg <= `FDS_R8_RST;
            ad1_reg <= 10'h000;
            ad2_reg <= 10'h000;
        end else begin
            sy1_reg <= sy_in;
            sy2_reg <= sy1_reg;
            rv1_reg <= reduced_value;
            rv2_reg <= rv1_reg;
            ad1_reg <= adc_data;
            ad2_reg <= ad1_reg;
        end
    end

    wire uv_s = sy2_reg[1];
    wire vmax_s = sy2_reg[2];
    wire drop_s = sy2_reg[3];
    wire ledlo_s = sy2_reg[4];
    wire imin_s = sy2_reg[5];
    wire hot_s = sy2_reg[6];
    wire cool_s = sy2_reg[7];
    wire cap_s = sy2_reg[8];
    wire cell_s = sy2_reg[9];
    wire ntc_s = sy2_reg[10];
    wire chg_s = sy2_reg[11];
    wire strb_s = sy2_reg[12];
    wire adone_s = sy2_reg[13];
    wire ired_s = sy2_reg[15];

    // undervoltage acts as a reset of every control register
    wire rst_all = sys_rst | uv_s;

    // ======================================================
    // registers
    logic [2:0] mode_reg, mode_next;
    logic [2:0] post_reg;
    logic strobe_on_reg, strobe_type_reg, ntc_on_reg;
    logic [1:0] range_reg;
    logic [1:0] txm_reg, txm_next;
    logic [7:0] tmo_reg;
    logic [5:0] chan_reg;
    logic [1:0] conv_reg, conv_next;
    logic [9:0] res_reg;
    logic [7:0] stat_reg, stat_next, ev;
    logic [7:0] mask_reg;
    logic [7:0] ilim_reg;
    logic ot_reg, strb_d_reg, chg_d_reg;
    fds_flash_t fst_reg, fst_next;
    fds_adc_t ast_reg, ast_next;
    logic [15:0] pre_reg;
    logic [7:0] tcnt_reg;

    wire wr_mode = wr && (addr == `FDS_A_MODE);
    wire wr_ctrl = wr && (addr == `FDS_A_CTRL);
    wire wr_tmo = wr && (addr == `FDS_A_TMO);
    wire wr_adc = wr && (addr == `FDS_A_ADC);
    wire wr_mask = wr && (addr == `FDS_A_MASK);
    wire rd_stat = rd && (addr == `FDS_A_STAT);

    // ======================================================
    // fault detection
    wire led_det_ok = !is_off(mode_reg) &&
                      (mode_reg != `FDS_M_PWM);
    wire open_led = vmax_s && drop_s;
    wire short_led = imin_s && ledlo_s &&
                     (range_reg != `FDS_RANGE_NODET);
    wire led_fault = led_det_ok && (open_led || short_led);
    wire cell_fault = !is_off(mode_reg) && cap_s && cell_s;
    wire ntc_fault = ntc_on_reg && ntc_s && !is_off(mode_reg);
    wire in_flash = (fst_reg == F_ON);
    wire ired_ev = in_flash && ired_s;
    wire hot_rise = hot_s && !ot_reg;
    wire strb_rise = strb_s && !strb_d_reg;
    wire strb_fall = !strb_s && strb_d_reg;

    // ======================================================
    // flash timer: prescaler ticks every timeout lsb
    wire tick = (pre_reg == 16'(`FDS_STEP_CYC - 1));
    wire expired = tick && (tcnt_reg == tmo_reg);
    wire strb_timed = strobe_on_reg && strobe_type_reg;
    wire end_strb = in_flash && strb_timed && strb_fall;
    wire end_tmo = in_flash && expired;
    wire flash_end = end_strb || end_tmo;
    wire tmo_fault = end_tmo && strb_timed;
    wire fl_start = (fst_next == F_ON) && !in_flash;

    always_comb begin
        fst_next = fst_reg;
        case (fst_reg)
            F_IDLE: begin
                if (mode_reg == `FDS_M_FLASH) begin
                    fst_next = strobe_on_reg ? F_WAIT : F_ON;
                end
            end
            F_WAIT: begin
                if (mode_reg != `FDS_M_FLASH) begin
                    fst_next = F_IDLE;
                end else if (strb_rise) begin
                    fst_next = F_ON;
                end
            end
            F_ON: begin
                if (flash_end || mode_reg != `FDS_M_FLASH) begin
                    fst_next = F_IDLE;
                end
            end
            default: fst_next = F_IDLE;
        endcase
    end

    // ======================================================
    // mode selection, faults take priority over software
    always_comb begin
        mode_next = mode_reg;
        txm_next = txm_reg;
        if (wr_mode) begin
            mode_next = wdata[2:0];
        end
        if (wr_ctrl) begin
            txm_next = wdata[6:5];
        end
        if (flash_end) begin
            mode_next = post_reg;
        end
        if (ntc_fault) begin
            mode_next = (post_reg == `FDS_M_DISCH) ?
                        `FDS_M_DISCH : `FDS_M_OFF;
        end
        if (cell_fault) begin
            mode_next = `FDS_M_DISCH;
        end
        if (led_fault) begin
            mode_next = `FDS_M_DISCH;
            if (txm_reg == `FDS_TXM_EXT_TORCH) begin
                txm_next = `FDS_TXM_RST;
            end
        end
    end

    // ======================================================
    // adc sequencing
    wire adc_go = (conv_reg == `FDS_CONV_NOW) ||
                  (conv_reg == `FDS_CONV_FL_ON && fl_start) ||
                  (conv_reg == `FDS_CONV_FL_OFF && flash_end);
    always_comb begin
        ast_next = ast_reg;
        case (ast_reg)
            A_IDLE: begin
                if (conv_reg != `FDS_CONV_IDLE) begin
                    ast_next = A_HOLD;
                end
            end
            A_HOLD: begin
                if (adc_go) begin
                    ast_next = A_BUSY;
                end
            end
            A_BUSY: begin
                if (adone_s) begin
                    ast_next = A_IDLE;
                end
            end
            default: ast_next = A_IDLE;
        endcase
    end
    wire adc_fin = (ast_reg == A_BUSY) && adone_s;
    always_comb begin
        conv_next = conv_reg;
        if (wr_adc && ast_reg == A_IDLE) begin
            conv_next = wdata[7:6];
        end
        if (adc_fin) begin
            conv_next = `FDS_CONV_IDLE;
        end
    end

    // ======================================================
    // status flags: a new event wins over the read clear
    always_comb begin
        ev = 8'h00;
        ev[`FDS_F_LED] = led_fault;
        ev[`FDS_F_OTEMP] = hot_rise && !is_chg(mode_reg);
        ev[`FDS_F_TMO] = tmo_fault;
        ev[`FDS_F_CELL] = cell_fault;
        ev[`FDS_F_NTC] = ntc_fault;
        ev[`FDS_F_IRED] = ired_ev;
        ev[`FDS_F_EOC] = chg_s && !chg_d_reg;
        ev[`FDS_F_ADC] = adc_fin;
        stat_next = (rd_stat ? 8'h00 : stat_reg) | ev;
    end

    // ======================================================
    // driver enables: off on faults and while die is hot
    // next value, so drivers drop on the edge the synced heat shows
    wire ot_next = ot_reg ? !cool_s : hot_s;
    wire run_ok = !is_off(mode_next) && !ot_next && !led_fault &&
                  !cell_fault && !ntc_fault && !tmo_fault;

    // ======================================================
    // read mux
    logic [7:0] rd_mux;
    always_comb begin
        case (addr)
            `FDS_A_ID: rd_mux = ID_CODE;
            `FDS_A_MODE: rd_mux = {2'b00, post_reg, mode_reg};
            `FDS_A_CTRL: rd_mux = {1'b0, txm_reg, range_reg,
                                   ntc_on_reg, strobe_type_reg,
                                   strobe_on_reg};
            `FDS_A_TMO: rd_mux = tmo_reg;
            `FDS_A_ADC: rd_mux = {conv_reg, chan_reg};
            `FDS_A_RES_HI: rd_mux = res_reg[9:2];
            `FDS_A_RES_LO: rd_mux = {6'h00, res_reg[1:0]};
            `FDS_A_STAT: rd_mux = stat_reg;
            `FDS_A_MASK: rd_mux = mask_reg;
            `FDS_A_ILIM: rd_mux = ilim_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    // ======================================================
    // state update
    always_ff @(posedge clk) begin
        if (rst_all) begin
            mode_reg <= `FDS_R3_RST;
            post_reg <= `FDS_R3_RST;
            strobe_on_reg <= 1'b0;
            strobe_type_reg <= 1'b0;
            ntc_on_reg <= 1'b0;
            range_reg <= 2'h0;
            txm_reg <= `FDS_TXM_RST;
            tmo_reg <= `FDS_R8_RST;
            chan_reg <= `FDS_R6_RST;
            conv_reg <= `FDS_CONV_IDLE;
            mask_reg <= `FDS_R8_RST;
        end else begin
            mode_reg <= mode_next;
            txm_reg <= txm_next;
            conv_reg <= conv_next;
            if (wr_mode) begin
                post_reg <= wdata[5:3];
            end
            if (wr_ctrl) begin
                strobe_on_reg <= wdata[0];
                strobe_type_reg <= wdata[1];
                ntc_on_reg <= wdata[2];
                range_reg <= wdata[4:3];
            end
            if (wr_tmo) begin
                tmo_reg <= wdata;
            end
            if (wr_adc) begin
                chan_reg <= wdata[5:0];
            end
            if (wr_mask) begin
                mask_reg <= wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst_all) begin
            stat_reg <= `FDS_R8_RST;
            ilim_reg <= `FDS_R8_RST;
            res_reg <= 10'h000;
            ot_reg <= 1'b0;
            strb_d_reg <= 1'b0;
            chg_d_reg <= 1'b0;
            fst_reg <= F_IDLE;
            ast_reg <= A_IDLE;
        end else begin
            stat_reg <= stat_next;
            ot_reg <= ot_next;
            strb_d_reg <= strb_s;
            chg_d_reg <= chg_s;
            fst_reg <= fst_next;
            ast_reg <= ast_next;
            if (ired_ev) begin
                ilim_reg <= rv2_reg;
            end
            if (adc_fin) begin
                res_reg <= ad2_reg;
            end
        end
    end

    // timeout counter runs only during the flash
    always_ff @(posedge clk) begin
        if (rst_all || !in_flash) begin
            pre_reg <= 16'h0000;
            tcnt_reg <= 8'h00;
        end else if (tick) begin
            pre_reg <= 16'h0000;
            tcnt_reg <= tcnt_reg + 8'h01;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end

    // ======================================================
    // outputs, all registered
    always_ff @(posedge clk) begin
        if (rst_all) begin
            rdata <= 8'h00;
            mode <= `FDS_R3_RST;
            dcdc_en <= 1'b0;
            sink_en <= 1'b0;
            ramp_down <= 1'b0;
            charge_pause <= 1'b0;
            txm_mode <= `FDS_TXM_RST;
            adc_channel <= `FDS_R6_RST;
            adc_start <= 1'b0;
            int_o <= 1'b0;
            int_oe_n <= 1'b1;
        end else begin
            rdata <= rd ? rd_mux : 8'h00;
            mode <= mode_next;
            dcdc_en <= run_ok;
            sink_en <= run_ok;
            ramp_down <= tmo_fault;
            charge_pause <= ot_next && is_chg(mode_next);
            txm_mode <= txm_next;
            adc_channel <= chan_reg;
            adc_start <= (ast_reg == A_HOLD) && adc_go;
            // pin only ever pulled low or released
            int_o <= 1'b0;
            int_oe_n <= ~|(stat_next & mask_reg);
        end
    end
endmodule : fds_supervisor

/* src/fds_regs.svh */
`ifndef FDS_REGS_SVH
`define FDS_REGS_SVH
// ==========================================================
// register offsets
`define FDS_A_ID 8'h00
`define FDS_A_MODE 8'h01
`define FDS_A_CTRL 8'h02
`define FDS_A_TMO 8'h03
`define FDS_A_ADC 8'h04
`define FDS_A_RES_HI 8'h05
`define FDS_A_RES_LO 8'h06
`define FDS_A_STAT 8'h07
`define FDS_A_MASK 8'h08
`define FDS_A_ILIM 8'h09
// ==========================================================
// mode codes
`define FDS_M_OFF 3'h0
`define FDS_M_DISCH 3'h1
`define FDS_M_PRECHG 3'h2
`define FDS_M_CHG 3'h3
`define FDS_M_TRANS 3'h4
`define FDS_M_PWM 3'h5
`define FDS_M_TORCH 3'h6
`define FDS_M_FLASH 3'h7
// ==========================================================
// fields and reset values
`define FDS_RANGE_NODET 2'h3
`define FDS_TXM_EXT_TORCH 2'h2
`define FDS_TXM_RST 2'h0
`define FDS_CONV_IDLE 2'h0
`define FDS_CONV_NOW 2'h1
`define FDS_CONV_FL_ON 2'h2
`define FDS_CONV_FL_OFF 2'h3
`define FDS_R8_RST 8'h00
`define FDS_R6_RST 6'h00
`define FDS_R3_RST 3'h0
// status flag bit positions
`define FDS_F_LED 0
`define FDS_F_OTEMP 1
`define FDS_F_TMO 2
`define FDS_F_CELL 3
`define FDS_F_NTC 4
`define FDS_F_IRED 5
`define FDS_F_EOC 6
`define FDS_F_ADC 7
// ==========================================================
// timing: timeout lsb in microseconds, clock in MHz
`define FDS_TMO_STEP_US 10
`define FDS_CLK_MHZ 25
`define FDS_STEP_CYC (`FDS_TMO_STEP_US * `FDS_CLK_MHZ)
`define FDS_NSYNC 16
`endif

/* src/fds_pkg.sv */
package fds_pkg;
    typedef enum logic [1:0] {F_IDLE, F_WAIT, F_ON} fds_flash_t;
    typedef enum logic [1:0] {A_IDLE, A_HOLD, A_BUSY} fds_adc_t;
endpackage : fds_pkg

/* tb/fds_checker.sv */
// ==========================================================
// protocol checker, sees only supervisor ports
module fds_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr,
    input wire logic uvlo,
    input wire logic die_hot,
    input wire logic cell_short,
    input wire logic cap_above_2v4,
    input wire logic ntc_low,
    input wire logic [2:0] mode,
    input wire logic dcdc_en,
    input wire logic sink_en,
    input wire logic ramp_down,
    input wire logic charge_pause,
    input wire logic adc_start,
    input wire logic int_o,
    input wire logic int_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // assertions
    a_int_drive_low: assert property (int_o == 1'b0)
        else $error("interrupt pin driven high");
    // five samples cover the two-flop sync plus the reset edge
    a_uvlo_holds_off: assert property (uvlo [*5] |->
        mode == 3'h0 && !dcdc_en && !sink_en && int_oe_n)
        else $error("undervoltage did not force shutdown");
    a_ramp_one_cycle: assert property (ramp_down |=> !ramp_down)
        else $error("ramp down pulse too long");
    a_adc_start_pulse: assert property (adc_start |=> !adc_start)
        else $error("conversion request longer than one cycle");
    a_cell_short_act: assert property (
        $rose(cell_short && cap_above_2v4) && mode == 3'h3
        ##1 (cell_short && cap_above_2v4) [*3]
        |-> ##[0:2] (mode == 3'h1 && !dcdc_en))
        else $error("cell short did not discharge");
    a_die_hot_off: assert property (
        (die_hot && (mode == 3'h6 || mode == 3'h7)) [*4]
        |-> !dcdc_en && !sink_en)
        else $error("drivers still on while die hot");
    a_hot_pause_chg: assert property ((die_hot && mode == 3'h3) [*4]
        |-> charge_pause)
        else $error("charging not paused while die hot");
    a_pwm_mode_kept: assert property (
        (mode == 3'h5 && !wr && !cell_short && !ntc_low && !uvlo) [*5]
        |=> mode == 3'h5)
        else $error("pwm mode left without cause");

    // ==========================================================
    // scenario cover
    c_cell_fault: cover property ($rose(mode == 3'h1));
    c_ramp: cover property (ramp_down);
    c_adc: cover property (adc_start);
endmodule : fds_checker

bind fds_supervisor fds_checker chk_u (
    .clk(clk), .sys_rst(sys_rst), .wr(wr), .uvlo(uvlo),
    .die_hot(die_hot), .cell_short(cell_short),
    .cap_above_2v4(cap_above_2v4), .ntc_low(ntc_low), .mode(mode),
    .dcdc_en(dcdc_en), .sink_en(sink_en), .ramp_down(ramp_down),
    .charge_pause(charge_pause), .adc_start(adc_start),
    .int_o(int_o), .int_oe_n(int_oe_n)
);

/* tb/fds_adc_model.sv */
// ==========================================================
// converter model: answers after lat cycles, done held 4 cycles
module fds_adc_model (
    input wire logic clk,
    input wire logic adc_start,
    input wire logic [9:0] value,
    input wire logic [7:0] lat,
    output logic adc_done,
    output logic [9:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        adc_done = 1'b0;
        adc_data = 10'h155;
    end
    always @(posedge clk) begin
        if (adc_start === 1'b1) begin
            repeat (lat) @(posedge clk);
            adc_data <= value;
            adc_done <= 1'b1;
            repeat (4) @(posedge clk);
            adc_done <= 1'b0;
            // stale data inverted so a late capture shows up
            adc_data <= ~value;
        end
    end
endmodule : fds_adc_model

/* tb/tb.sv */
`include "fds_regs.svh"
`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("mismatch %s exp %0h got %0h", nm, e, g); \
        end \
    end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ID = 8'h3C; // arbitrary value
    localparam int LIMIT = 8000;
    logic clk = 1'b0;
    logic sys_rst, wr, rd, uvlo, vout_at_max, src_drop_low, led_out_low;
    logic led_cur_above_min, die_hot, die_cool, cap_above_2v4, cell_short;
    logic ntc_low, cur_reduced, charge_done, strobe_pin, adc_done;
    logic [7:0] addr, wdata, rdata, reduced_value, lat, e_now;
    logic [9:0] adc_data, adc_val;
    logic [2:0] mode;
    logic [1:0] txm_mode;
    logic [5:0] adc_channel;
    logic dcdc_en, sink_en, ramp_down, charge_pause, adc_start;
    logic int_o, int_oe_n;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h1db5;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    int starts = 0;

    fds_supervisor #(.ID_CODE(ID)) dut_u (.clk, .sys_rst, .addr, .wdata,
        .wr, .rd, .rdata, .uvlo, .vout_at_max, .src_drop_low, .led_out_low,
        .led_cur_above_min, .die_hot, .die_cool, .cap_above_2v4,
        .cell_short, .ntc_low, .cur_reduced, .reduced_value, .charge_done,
        .strobe_pin, .adc_done, .adc_data, .mode, .dcdc_en, .sink_en,
        .ramp_down, .charge_pause, .txm_mode, .adc_channel, .adc_start,
        .int_o, .int_oe_n);
    fds_adc_model adc_u (.clk, .adc_start, .value(adc_val), .lat,
        .adc_done, .adc_data);

    always #20 clk = ~clk;

    // ==========================================================
    // tasks
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // strobe low for one edge so back-to-back calls never re-drive it
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        cyc(1);
        wr <= 1'b0;
        cyc(1);
    endtask : wr_reg
    task rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        cyc(1);
    endtask : rd_exp
    task rst_dut;
        {addr, wdata, wr, rd, uvlo, vout_at_max, src_drop_low} <= '0;
        {led_out_low, led_cur_above_min, die_hot, cap_above_2v4} <= '0;
        {cell_short, ntc_low, cur_reduced, charge_done} <= '0;
        {strobe_pin, reduced_value, adc_val} <= '0;
        die_cool <= 1'b1;
        lat <= 8'd2;
        sys_rst <= 1'b1;
        cyc(3);
        sys_rst <= 1'b0;
        cyc(1);
    endtask : rst_dut

    // ==========================================================
    // read-data monitor, timeout
    always @(posedge clk) begin
        if (rd_seen) begin
            e_now = exp_q.size() ? exp_q.pop_front() : 8'hXX;
            `CHK("rdata", e_now, rdata)
        end
        rd_seen <= rd;
        if (adc_start === 1'b1) starts++;
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            close_out();
        end
    end

    // ==========================================================
    // scenarios
    initial begin : main
        int i, s0;
        rst_dut();
        rd_exp(`FDS_A_ID, ID);
        rd_exp(8'h0A, 8'h00);
        rd_exp(`FDS_A_MASK, `FDS_R8_RST);
        wr_reg(`FDS_A_CTRL, 8'h40);
        wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_PWM});
        vout_at_max <= 1'b1;
        src_drop_low <= 1'b1;
        cyc(8);
        `CHK("mode", `FDS_M_PWM, mode)
        rd_exp(`FDS_A_STAT, 8'h00);
        wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_TORCH});
        cyc(6);
        `CHK("mode", `FDS_M_DISCH, mode)
        `CHK("dcdc_en", 1'b0, dcdc_en)
        `CHK("sink_en", 1'b0, sink_en)
        `CHK("txm_mode", `FDS_TXM_RST, txm_mode)
        `CHK("int_oe_n", 1'b1, int_oe_n)
        rd_exp(`FDS_A_STAT, 8'h01);
        rst_dut();
        wr_reg(`FDS_A_CTRL, 8'h18);
        wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_TORCH});
        led_cur_above_min <= 1'b1;
        led_out_low <= 1'b1;
        cyc(8);
        `CHK("mode", `FDS_M_TORCH, mode)
        wr_reg(`FDS_A_CTRL, 8'h00);
        cyc(6);
        `CHK("mode", `FDS_M_DISCH, mode)
        rd_exp(`FDS_A_STAT, 8'h01);
        rst_dut();
        wr_reg(`FDS_A_MASK, 8'hFF);
        wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_CHG});
        cell_short <= 1'b1;
        cyc(8);
        `CHK("mode", `FDS_M_CHG, mode)
        cap_above_2v4 <= 1'b1;
        cyc(6);
        `CHK("mode", `FDS_M_DISCH, mode)
        `CHK("dcdc_en", 1'b0, dcdc_en)
        `CHK("int_oe_n", 1'b0, int_oe_n)
        rd_exp(`FDS_A_STAT, 8'h08);
        cyc(2);
        `CHK("int_oe_n", 1'b1, int_oe_n)
        rst_dut();
        wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_TORCH});
        die_cool <= 1'b0;
        die_hot <= 1'b1;
        cyc(6);
        `CHK("sink_en", 1'b0, sink_en)
        `CHK("mode", `FDS_M_TORCH, mode)
        die_hot <= 1'b0;
        die_cool <= 1'b1;
        cyc(6);
        `CHK("sink_en", 1'b1, sink_en)
        rd_exp(`FDS_A_STAT, 8'h02);
        wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_CHG});
        die_cool <= 1'b0;
        die_hot <= 1'b1;
        cyc(6);
        `CHK("charge_pause", 1'b1, charge_pause)
        {die_hot, die_cool, charge_done} <= 3'b011;
        cyc(6);
        `CHK("charge_pause", 1'b0, charge_pause)
        rd_exp(`FDS_A_STAT, 8'h40);
        for (i = 1; i <= 2; i++) begin
            rst_dut();
            wr_reg(`FDS_A_CTRL, 8'h04);
            wr_reg(`FDS_A_MODE, {2'b00, i[2:0], `FDS_M_TORCH});
            ntc_low <= 1'b1;
            cyc(6);
            `CHK("mode", (i == 1) ? 3'h1 : 3'h0, mode)
            `CHK("dcdc_en", 1'b0, dcdc_en)
            rd_exp(`FDS_A_STAT, 8'h10);
        end
        rst_dut();
        wr_reg(`FDS_A_CTRL, 8'h03);
        wr_reg(`FDS_A_MODE, 8'h1F);
        strobe_pin <= 1'b1;
        for (i = 0; i < 400 && ramp_down !== 1'b1; i++) cyc(1);
        `CHK("ramp_at", 1'b1, (i > 245 && i < 262))
        cyc(2);
        `CHK("mode", `FDS_M_CHG, mode)
        rd_exp(`FDS_A_STAT, 8'h04);
        strobe_pin <= 1'b0;
        wr_reg(`FDS_A_MODE, 8'h1F);
        strobe_pin <= 1'b1;
        cyc(20);
        strobe_pin <= 1'b0;
        cyc(8);
        `CHK("mode", `FDS_M_CHG, mode)
        rd_exp(`FDS_A_STAT, 8'h00);
        rst_dut();
        seed = xs(seed);
        wr_reg(`FDS_A_MODE, 8'h37);
        reduced_value <= seed[7:0];
        cur_reduced <= 1'b1;
        cyc(6);
        cur_reduced <= 1'b0;
        cyc(4);
        `CHK("mode", `FDS_M_FLASH, mode)
        `CHK("dcdc_en", 1'b1, dcdc_en)
        rd_exp(`FDS_A_ILIM, seed[7:0]);
        rd_exp(`FDS_A_STAT, 8'h20);
        cyc(260);
        `CHK("mode", `FDS_M_TORCH, mode)
        rd_exp(`FDS_A_STAT, 8'h00);
        for (i = 1; i <= 3; i++) begin
            rst_dut();
            seed = xs(seed);
            adc_val <= seed[17:8];
            lat <= (i == 2) ? 8'd40 : 8'd2;
            s0 = starts;
            wr_reg(`FDS_A_ADC, {i[1:0], seed[5:0]});
            cyc(10);
            `CHK("adc_channel", seed[5:0], adc_channel)
            `CHK("starts", (i == 1) ? 1 : 0, starts - s0)
            wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_FLASH});
            cyc(20);
            `CHK("starts", (i < 3) ? 1 : 0, starts - s0)
            cyc(300);
            `CHK("starts", 1, starts - s0)
            rd_exp(`FDS_A_RES_HI, seed[17:10]);
            rd_exp(`FDS_A_RES_LO, {6'h00, seed[9:8]});
            rd_exp(`FDS_A_ADC, {`FDS_CONV_IDLE, seed[5:0]});
            rd_exp(`FDS_A_STAT, 8'h80);
        end
        wr_reg(`FDS_A_MASK, 8'hFF);
        wr_reg(`FDS_A_MODE, {5'h0, `FDS_M_TORCH});
        charge_done <= 1'b1;
        cyc(6);
        `CHK("int_oe_n", 1'b0, int_oe_n)
        uvlo <= 1'b1;
        cyc(6);
        `CHK("mode", `FDS_M_OFF, mode)
        `CHK("int_oe_n", 1'b1, int_oe_n)
        uvlo <= 1'b0;
        cyc(4);
        rd_exp(`FDS_A_MASK, `FDS_R8_RST);
        cyc(2);
        close_out();
    end
endmodule : tb
